// File: dv/sfr_read_status_checker.sv
// Port assertions of the read and status logic
`timescale 1ns/1ns
module sfr_read_status_checker (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic o_mem_req_valid,
  input wire logic i_mem_req_ready,
  input sfr_pkg::sfr_mem_req_s o_mem_req
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  a_oe_drop_cs: assert property ($rose(i_cs_n) |-> ##[1:6] !o_so_oe)
    else $error("serial out still driven after chip select rise");
  a_cs_high_quiet: assert property (i_cs_n [*8] |-> !o_so_oe)
    else $error("serial out driven while deselected");
  a_oe_rise_ok: assert property ($rose(o_so_oe) |-> !i_cs_n && !i_sck && $past(!i_cs_n, 8))
    else $error("serial out enabled outside a selected low clock phase");
  a_so_after_fall: assert property (o_so_oe && $past(o_so_oe) && $changed(o_so) |-> !i_sck)
    else $error("serial out changed while clock high");
  a_req_hold: assert property (o_mem_req_valid && !i_mem_req_ready |=> o_mem_req_valid && $stable(o_mem_req))
    else $error("store request dropped or changed before taken");
  a_req_gap: assert property (o_mem_req_valid && i_mem_req_ready |=> !o_mem_req_valid)
    else $error("store request not cleared after acceptance");
  a_req_byte_step: assert property ((o_mem_req_valid && i_mem_req_ready) ##2 o_mem_req_valid |->
    o_mem_req.src == $past(o_mem_req.src, 2) && o_mem_req.byte_in_page_addr ==
    (($past(o_mem_req.byte_in_page_addr, 2) == 10'h20f) ? 10'h000 : $past(o_mem_req.byte_in_page_addr, 2) + 10'h001))
    else $error("next store byte address wrong");
  a_req_page_keep: assert property ((o_mem_req_valid && i_mem_req_ready) ##2 o_mem_req_valid |->
    $past(o_mem_req.byte_in_page_addr, 2) == 10'h20f || o_mem_req.page_addr == $past(o_mem_req.page_addr, 2))
    else $error("page changed inside a page");
endmodule // sfr_read_status_checker

bind sfr_read_status sfr_read_status_checker u_sfr_read_status_checker (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_cs_n(i_cs_n), .i_sck(i_sck), .o_so(o_so), .o_so_oe(o_so_oe), .o_mem_req_valid(o_mem_req_valid),
  .i_mem_req_ready(i_mem_req_ready), .o_mem_req(o_mem_req));

// File: dv/sfr_read_status_tb.sv
// Self-checking bench of the read and status logic
`timescale 1ns/1ns
module sfr_read_status_tb;
  // Density code value is arbitrary
  localparam logic [3:0] DENS = 4'h6;
  localparam logic [7:0] BOPC [4] = '{8'h54, 8'hd4, 8'h56, 8'hd6};
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_cs_n = 1'b1;
  logic i_sck = 1'b0;
  logic i_si = 1'b0;
  logic busy = 1'b0;
  logic cmp = 1'b0;
  logic slow = 1'b0;
  logic o_so, o_so_oe, rq_v, rq_rdy, rs_v, rs_rdy;
  logic [7:0] rs_d;
  logic [31:0] junk;
  sfr_pkg::sfr_mem_req_s rq;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;

  sfr_read_status #(.P_DENSITY_CODE(DENS)) u_sfr_read_status (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_cs_n(i_cs_n), .i_sck(i_sck), .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe), .i_busy(busy),
    .i_compare_mismatch(cmp), .o_mem_req_valid(rq_v), .i_mem_req_ready(rq_rdy), .o_mem_req(rq),
    .i_mem_rsp_valid(rs_v), .o_mem_rsp_ready(rs_rdy), .i_mem_rsp_data(rs_d));
  sfr_store_model u_sfr_store_model (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_slow(slow), .i_req_valid(rq_v),
    .o_req_ready(rq_rdy), .i_req(rq), .o_rsp_valid(rs_v), .i_rsp_ready(rs_rdy), .o_rsp_data(rs_d));

  initial begin
    forever #25 i_mclk = ~i_mclk;
  end

  task end_of_test;
    $display("checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      end_of_test;
    end
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Mode 0 bit: low 5 mclk, high 3; output sampled just before the rise
  task bit1(input logic b, output logic r);
    @(negedge i_mclk);
    i_si = b;
    repeat (4) @(negedge i_mclk);
    r = o_so;
    i_sck = 1'b1;
    repeat (3) @(negedge i_mclk);
    i_sck = 1'b0;
  endtask

  task shift(input logic [31:0] v, input int n, output logic [31:0] r);
    logic b;
    r = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      bit1(v[i], b);
      r = {r[30:0], b};
    end
  endtask

  task begin_cmd(input logic [7:0] opc);
    @(negedge i_mclk);
    i_cs_n = 1'b0;
    repeat (4) @(negedge i_mclk);
    shift({24'h0, opc}, 8, junk);
  endtask

  task end_cmd;
    @(negedge i_mclk);
    i_cs_n = 1'b1;
    repeat (8) @(negedge i_mclk);
    chk({7'h0, o_so_oe}, 8'h00, "serial out floated");
  endtask

  // Legacy opcodes put the first data bit one clock earlier
  task read_chk(input logic [7:0] opc, input logic [23:0] adr, input int ndum, input sfr_pkg::sfr_mem_req_s a,
      input logic nxt_page);
    begin_cmd(opc);
    shift({8'h0, adr}, 24, junk);
    shift(32'hffffffff, ndum - (opc[7] ? 0 : 1), junk);
    for (int k = 0; k < 3; k++) begin
      shift(32'h0, 8, junk);
      chk(junk[7:0], a.byte_in_page_addr[7:0] ^ a.page_addr[7:0] ^ {6'h00, a.src}, "read byte");
      if (a.byte_in_page_addr == 10'h20f) begin
        a.byte_in_page_addr = 10'h000;
        if (nxt_page) a.page_addr = a.page_addr + 12'h001;
      end else begin
        a.byte_in_page_addr = a.byte_in_page_addr + 10'h001;
      end
    end
    end_cmd;
  endtask

  // Page cross and array wrap, reserved bits set
  task t_array;
    for (int i = 0; i < 2; i++) begin
      read_chk(i ? 8'he8 : 8'h68, {2'h3, i ? 12'h123 : 12'hfff, 10'h20e}, 32,
        '{sfr_pkg::SFR_SRC_ARRAY, i ? 12'h123 : 12'hfff, 10'h20e}, 1'b1);
    end
    $display("t_array done");
  endtask

  task t_abort;
    begin_cmd(8'he8);
    shift(32'h0, 24, junk);
    shift(32'h0, 40, junk);
    end_cmd;
    begin_cmd(8'h11);
    shift(32'h0, 32, junk);
    chk({7'h0, o_so_oe}, 8'h00, "unknown opcode output");
    end_cmd;
    $display("t_abort done");
  endtask

  // Wrap inside page with stalling store
  task t_page;
    slow = 1'b1;
    for (int i = 0; i < 2; i++) begin
      read_chk(i ? 8'hd2 : 8'h52, {2'h0, 12'h0a5, 10'h20f}, 32, '{sfr_pkg::SFR_SRC_ARRAY, 12'h0a5, 10'h20f}, 1'b0);
    end
    slow = 1'b0;
    $display("t_page done");
  endtask

  task t_buf;
    for (int i = 0; i < 4; i++) begin
      read_chk(BOPC[i], {14'h3fff, 10'h20e}, 8,
        '{i < 2 ? sfr_pkg::SFR_SRC_BUF1 : sfr_pkg::SFR_SRC_BUF2, 12'h000, 10'h20e}, 1'b0);
    end
    $display("t_buf done");
  endtask

  task t_status;
    for (int i = 0; i < 2; i++) begin
      busy = 1'b1;
      cmp = 1'b1;
      begin_cmd(i ? 8'hd7 : 8'h57);
      shift(32'h0, 8, junk);
      busy = 1'b0;
      cmp = 1'b0;
      chk(junk[7:0] & 8'hfc, {2'b01, DENS, 2'b00}, "status busy");
      shift(32'h0, 8, junk);
      chk(junk[7:0] & 8'hfc, {2'b10, DENS, 2'b00}, "status repeat");
      repeat (5) @(negedge i_mclk);
      chk({7'h0, o_so}, 8'h01, "halted ready");
      busy = 1'b1;
      repeat (3) @(negedge i_mclk);
      chk({7'h0, o_so}, 8'h00, "halted busy");
      busy = 1'b0;
      repeat (3) @(negedge i_mclk);
      chk({7'h0, o_so}, 8'h01, "halted ready again");
      end_cmd;
    end
    $display("t_status done");
  endtask

  initial begin
    repeat (12) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    t_array;
    t_abort;
    t_page;
    t_buf;
    t_status;
    end_of_test;
  end
endmodule // sfr_read_status_tb

// File: dv/sfr_store_model.sv
// Store stand-in answering byte reads in order, at full or stalling pace
`timescale 1ns/1ns
module sfr_store_model (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_slow,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input sfr_pkg::sfr_mem_req_s i_req,
  output logic o_rsp_valid,
  input wire logic i_rsp_ready,
  output logic [7:0] o_rsp_data
);
  logic [7:0] q[$];
  logic [3:0] tick;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_req_ready <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_data <= 8'h00;
      tick <= 4'h0;
      q.delete();
    end else begin
      tick <= tick + 4'h1;
      o_req_ready <= !i_slow || tick[1];
      if (i_req_valid && o_req_ready) begin
        q.push_back(i_req.byte_in_page_addr[7:0] ^ i_req.page_addr[7:0] ^ {6'h00, i_req.src});
      end
      // Released data lines show the inverse so stale bytes cannot match
      if (o_rsp_valid && i_rsp_ready) begin
        o_rsp_valid <= 1'b0;
        o_rsp_data <= ~o_rsp_data;
      end else if (!o_rsp_valid && q.size() > 0 && (!i_slow || tick[2])) begin
        o_rsp_valid <= 1'b1;
        o_rsp_data <= q.pop_front();
      end
    end
  end
endmodule // sfr_store_model

// File: verilog/sfr_defs.svh
// Constants of the serial flash read and status logic
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH

`define SFR_OPC_ARRAY_LEG 8'h68
`define SFR_OPC_ARRAY_SPI 8'he8
`define SFR_OPC_PAGE_LEG 8'h52
`define SFR_OPC_PAGE_SPI 8'hd2
`define SFR_OPC_BUF1_LEG 8'h54
`define SFR_OPC_BUF1_SPI 8'hd4
`define SFR_OPC_BUF2_LEG 8'h56
`define SFR_OPC_BUF2_SPI 8'hd6
`define SFR_OPC_STAT_LEG 8'h57
`define SFR_OPC_STAT_SPI 8'hd7
`define SFR_OPC_MODE_BIT 7

`define SFR_CNT_OPC_END 7'h08
`define SFR_CNT_ADDR_END 7'h20
`define SFR_CNT_MEM_DATA 7'h40
`define SFR_CNT_BUF_DATA 7'h28
`define SFR_CNT_MAX 7'h7f

`define SFR_PAGE_LAST_BYTE 10'h20f
`define SFR_ADDR_PAGE_MSB 21
`define SFR_ADDR_PAGE_LSB 10
`define SFR_ADDR_BYTE_MSB 9

`define SFR_STAT_READY_BIT 7
`define SFR_STAT_MISMATCH_BIT 6
`define SFR_STAT_DENSITY_LSB 2
`define SFR_STAT_RESERVED 2'h0
`define SFR_UNDERRUN_BYTE 8'hff

`define SFR_FIFO_WIDTH 8
`define SFR_FIFO_DEPTH 32

`endif

// File: verilog/sfr_pkg.sv
// Types of the serial flash read and status logic
package sfr_pkg;

  typedef enum logic [1:0] {SFR_SRC_ARRAY, SFR_SRC_BUF1, SFR_SRC_BUF2} sfr_src_e;

  typedef enum logic [2:0] {SFR_K_NONE, SFR_K_ARRAY, SFR_K_PAGE, SFR_K_BUF, SFR_K_STATUS} sfr_kind_e;

  typedef enum logic [2:0] {SFR_ST_IDLE, SFR_ST_OPC, SFR_ST_ADDR, SFR_ST_LEAD, SFR_ST_STREAM, SFR_ST_SKIP} sfr_state_e;

  // For buffer reads byte_in_page_addr carries buffer_byte_addr
  typedef struct packed {
    sfr_src_e src;
    logic [11:0] page_addr;
    logic [9:0] byte_in_page_addr;
  } sfr_mem_req_s;

  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic sck_m;
    logic sck_s;
    logic sck_d;
    logic si_m;
    logic si_s;
  } sfr_sync_s;

  typedef struct packed {
    sfr_sync_s sy;
    sfr_state_e st;
    sfr_kind_e kind;
    logic spi;
    logic [6:0] cnt;
    logic [22:0] sin;
    logic pf_on;
    sfr_mem_req_s pf;
    logic req_valid;
    logic req_old;
    sfr_mem_req_s req;
    logic [5:0] outstanding;
    logic [5:0] drop;
    logic [7:0] shreg;
    logic [2:0] bit_idx;
    logic load_next;
    logic so;
    logic oe;
  } sfr_top_s;

endpackage

// File: verilog/sfr_read_status.sv
// Prefetch FIFO and the read and status command logic of the serial flash
`timescale 1ns/1ns
`include "sfr_defs.svh"

module sfr_fifo #(
  parameter int W = `SFR_FIFO_WIDTH,
  parameter int D = `SFR_FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data,
  output logic [$clog2(D):0] o_level
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic in_ready;
    logic out_valid;
  } sfr_fifo_s;

  sfr_fifo_s s_r;
  sfr_fifo_s s_nxt;
  logic wr;
  logic rd;

  assign wr = i_in_valid & s_r.in_ready;
  assign rd = i_out_ready & s_r.out_valid;

  always_comb begin
    s_nxt = s_r;
    if (i_flush) begin
      s_nxt.wp = '0;
      s_nxt.rp = '0;
      s_nxt.cnt = '0;
    end else begin
      if (wr) begin
        s_nxt.mem[s_r.wp] = i_in_data;
        s_nxt.wp = s_r.wp + 1'b1;
      end
      if (rd) begin
        s_nxt.rp = s_r.rp + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end
    // Registered flags keep the handshake outputs glitch free
    s_nxt.in_ready = s_nxt.cnt < (AW+1)'(D);
    s_nxt.out_valid = s_nxt.cnt != '0;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_in_ready = s_r.in_ready;
  assign o_out_valid = s_r.out_valid;
  assign o_out_data = s_r.mem[s_r.rp];
  assign o_level = s_r.cnt;
endmodule // sfr_fifo

// Operation
// [RL1] A command starts at chip select low: 8-bit opcode, then address.
// [RL2] Opcode, address and data travel most significant bit first.
// [RL3] Array location is 12-bit page_addr plus 10-bit byte_in_page_addr.
// [RL4] Opcode category picks idle clock style and first data cycle.
// [RL5] Opcodes 68H/E8H start continuous read: 24 address, 32 dummy bits.
// [RL6] Two leading address bits ignored; then page_addr, then starting byte.
// [RL7] After dummies each clock outputs next bit; address advances itself.
// [RL8] Continuous read crosses page end into next page seamlessly.
// [RL9] Continuous read wraps from array end to first page seamlessly.
// [RL10] Host keeps chip select low for the whole read.
// [RL11] Chip select rising ends any read and floats serial output.
// [RL12] Array reads never change either SRAM buffer.
// [RL13] Opcodes 52H/D2H start page read with same address and dummies.
// [RL14] Page read wraps to first byte of the same page.
// [RL15] Buffer one uses 54H/D4H, buffer two 56H/D6H.
// [RL16] Buffer read: 14 dummies, 10-bit buffer_byte_addr, 8 dummies, data.
// [RL17] Buffer read wraps to first byte of the same buffer.
// [RL18] Opcodes 57H/D7H send the status byte, bit 7 first.
// [RL19] Status byte repeats from bit 7 with fresh values each time.
// [RL20] Status bit 7 is ready_flag: 1 idle, 0 busy.
// [RL21] Status bit 6 is compare_mismatch_flag: 1 means a difference.
// [RL22] Bits 5..2 hold fixed density code; low bits reserved.
// [RL23] Device samples input on rising, changes output after falling edges.
// [RL24] Clock halted after bit 7: pin follows live ready_flag.
module sfr_read_status #(
  // Density code value is arbitrary
  parameter logic [3:0] P_DENSITY_CODE = 4'h5
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  input wire logic i_busy,
  input wire logic i_compare_mismatch,
  output logic o_mem_req_valid,
  input wire logic i_mem_req_ready,
  output sfr_pkg::sfr_mem_req_s o_mem_req,
  input wire logic i_mem_rsp_valid,
  output logic o_mem_rsp_ready,
  input wire logic [7:0] i_mem_rsp_data
);
  sfr_pkg::sfr_top_s s_r;
  sfr_pkg::sfr_top_s s_nxt;
  logic sck_rise;
  logic sck_fall;
  logic rsp_hs;
  logic req_hs;
  logic abort;
  logic pop;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_data;
  logic [5:0] fifo_level;
  logic [7:0] opc;
  logic [23:0] addr;
  logic [7:0] stat;

  function automatic sfr_pkg::sfr_mem_req_s next_loc(input sfr_pkg::sfr_mem_req_s a, input logic to_next_page);
    sfr_pkg::sfr_mem_req_s r;
    r = a;
    if (a.byte_in_page_addr >= `SFR_PAGE_LAST_BYTE) begin
      r.byte_in_page_addr = '0;
      // Page counter rolls over 12 bits, wrapping the array to page 0
      if (to_next_page) begin
        r.page_addr = a.page_addr + 12'h001;
      end
    end else begin
      r.byte_in_page_addr = a.byte_in_page_addr + 10'h001;
    end
    return r;
  endfunction

  // Edge detection reads only the second and third sampling stages
  assign sck_rise = s_r.sy.sck_s & ~s_r.sy.sck_d;
  assign sck_fall = ~s_r.sy.sck_s & s_r.sy.sck_d;
  assign rsp_hs = i_mem_rsp_valid & fifo_in_ready;
  assign req_hs = s_r.req_valid & i_mem_req_ready;
  // [RL11] Deselect ends command
  assign abort = s_r.sy.cs_s & (s_r.st != sfr_pkg::SFR_ST_IDLE);
  assign opc = {s_r.sin[6:0], s_r.sy.si_s};
  assign addr = {s_r.sin, s_r.sy.si_s};
  // Status byte is built live, so every repeat sees fresh flags; a halted poll drives ~i_busy directly
  assign stat = {
    // [RL20] Ready flag first
    ~i_busy,
    // [RL21] Compare result next
    i_compare_mismatch,
    // [RL22] Fixed density, reserved zeros
    P_DENSITY_CODE, `SFR_STAT_RESERVED};

  sfr_fifo #(.W(`SFR_FIFO_WIDTH), .D(`SFR_FIFO_DEPTH)) u_fifo (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_flush(abort),
    .i_in_valid(i_mem_rsp_valid & (s_r.drop == 6'h00)),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_mem_rsp_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(pop),
    .o_out_data(fifo_data),
    .o_level(fifo_level)
  );

  always_comb begin
    s_nxt = s_r;
    pop = 1'b0;
    s_nxt.sy.cs_m = i_cs_n;
    s_nxt.sy.cs_s = s_r.sy.cs_m;
    s_nxt.sy.sck_m = i_sck;
    s_nxt.sy.sck_s = s_r.sy.sck_m;
    s_nxt.sy.sck_d = s_r.sy.sck_s;
    s_nxt.sy.si_m = i_si;
    s_nxt.sy.si_s = s_r.sy.si_m;

    // Responses of aborted commands are swallowed before new data
    if (rsp_hs) begin
      if (s_r.drop != 6'h00) begin
        s_nxt.drop = s_r.drop - 6'h01;
      end else begin
        s_nxt.outstanding = s_r.outstanding - 6'h01;
      end
    end
    // [RL7] Accepted request counted as outstanding or to be dropped
    if (req_hs) begin
      s_nxt.req_valid = 1'b0;
      s_nxt.req_old = 1'b0;
      if (s_r.req_old) begin
        s_nxt.drop = s_nxt.drop + 6'h01;
      end else begin
        s_nxt.outstanding = s_nxt.outstanding + 6'h01;
      end
    end
    // [RL12] Reads only, buffers untouched
    if (s_r.pf_on && !s_r.req_valid &&
        ({1'b0, fifo_level} + {1'b0, s_r.outstanding}) < 7'(`SFR_FIFO_DEPTH)) begin
      s_nxt.req_valid = 1'b1;
      s_nxt.req = s_r.pf;
      // [RL8] [RL9] [RL14] [RL17] Wrap per command
      s_nxt.pf = next_loc(s_r.pf, s_r.kind == sfr_pkg::SFR_K_ARRAY);
    end

    if (s_r.sy.cs_s) begin
      s_nxt.st = sfr_pkg::SFR_ST_IDLE;
      s_nxt.kind = sfr_pkg::SFR_K_NONE;
      s_nxt.cnt = '0;
      s_nxt.pf_on = 1'b0;
      s_nxt.load_next = 1'b0;
      s_nxt.bit_idx = '0;
      // [RL11] Output floats
      s_nxt.oe = 1'b0;
      s_nxt.so = 1'b0;
      if (abort) begin
        s_nxt.drop = s_nxt.drop + s_nxt.outstanding;
        s_nxt.outstanding = '0;
        s_nxt.req_old = s_nxt.req_valid;
      end
    end else if (s_r.st == sfr_pkg::SFR_ST_IDLE) begin
      // [RL1] Select starts a command
      s_nxt.st = sfr_pkg::SFR_ST_OPC;
      s_nxt.cnt = '0;
    end else begin
      // [RL23] Sample on rising edge
      if (sck_rise) begin
        // [RL2] Shift in, first bit highest
        s_nxt.sin = {s_r.sin[21:0], s_r.sy.si_s};
        if (s_r.cnt != `SFR_CNT_MAX) begin
          s_nxt.cnt = s_r.cnt + 7'h01;
        end
        unique case (s_r.st)
          sfr_pkg::SFR_ST_OPC: begin
            if (s_nxt.cnt == `SFR_CNT_OPC_END) begin
              // [RL4] Category from opcode
              s_nxt.spi = opc[`SFR_OPC_MODE_BIT];
              s_nxt.st = sfr_pkg::SFR_ST_ADDR;
              s_nxt.pf.src = sfr_pkg::SFR_SRC_ARRAY;
              unique case (opc)
                // [RL5] Continuous read
                `SFR_OPC_ARRAY_LEG, `SFR_OPC_ARRAY_SPI: s_nxt.kind = sfr_pkg::SFR_K_ARRAY;
                // [RL13] Page read
                `SFR_OPC_PAGE_LEG, `SFR_OPC_PAGE_SPI: s_nxt.kind = sfr_pkg::SFR_K_PAGE;
                // [RL15] Buffer select
                `SFR_OPC_BUF1_LEG, `SFR_OPC_BUF1_SPI: begin
                  s_nxt.kind = sfr_pkg::SFR_K_BUF;
                  s_nxt.pf.src = sfr_pkg::SFR_SRC_BUF1;
                end
                `SFR_OPC_BUF2_LEG, `SFR_OPC_BUF2_SPI: begin
                  s_nxt.kind = sfr_pkg::SFR_K_BUF;
                  s_nxt.pf.src = sfr_pkg::SFR_SRC_BUF2;
                end
                // [RL18] Status follows opcode directly
                `SFR_OPC_STAT_LEG, `SFR_OPC_STAT_SPI: begin
                  s_nxt.kind = sfr_pkg::SFR_K_STATUS;
                  s_nxt.st = sfr_pkg::SFR_ST_STREAM;
                  s_nxt.load_next = 1'b1;
                end
                default: begin
                  s_nxt.kind = sfr_pkg::SFR_K_NONE;
                  s_nxt.st = sfr_pkg::SFR_ST_SKIP;
                end
              endcase
            end
          end
          sfr_pkg::SFR_ST_ADDR: begin
            // [RL3] [RL6] [RL16] Address capture
            if (s_nxt.cnt == `SFR_CNT_ADDR_END) begin
              s_nxt.pf.page_addr = (s_r.kind == sfr_pkg::SFR_K_BUF) ? 12'h000 :
                                   addr[`SFR_ADDR_PAGE_MSB:`SFR_ADDR_PAGE_LSB];
              s_nxt.pf.byte_in_page_addr = addr[`SFR_ADDR_BYTE_MSB:0];
              s_nxt.pf_on = 1'b1;
              s_nxt.st = sfr_pkg::SFR_ST_LEAD;
            end
          end
          sfr_pkg::SFR_ST_LEAD: begin
            // [RL4] Legacy category starts one clock earlier
            if (s_nxt.cnt == (((s_r.kind == sfr_pkg::SFR_K_BUF) ? `SFR_CNT_BUF_DATA : `SFR_CNT_MEM_DATA)
                               - {6'h00, ~s_r.spi})) begin
              s_nxt.st = sfr_pkg::SFR_ST_STREAM;
              s_nxt.load_next = 1'b1;
            end
          end
          sfr_pkg::SFR_ST_STREAM, sfr_pkg::SFR_ST_SKIP, sfr_pkg::SFR_ST_IDLE: begin
          end
        endcase
      end
      // [RL23] Output changes after falling edge
      if (sck_fall && s_r.st == sfr_pkg::SFR_ST_STREAM) begin
        s_nxt.oe = 1'b1;
        if (s_r.load_next || s_r.bit_idx == 3'h0) begin
          s_nxt.load_next = 1'b0;
          s_nxt.bit_idx = 3'h7;
          if (s_r.kind == sfr_pkg::SFR_K_STATUS) begin
            // [RL19] Fresh status each repeat
            s_nxt.shreg = stat;
          end else begin
            // [RL7] Next byte from prefetch; underrun shows filler
            pop = fifo_out_valid;
            s_nxt.shreg = fifo_out_valid ? fifo_data : `SFR_UNDERRUN_BYTE;
          end
          s_nxt.so = s_nxt.shreg[7];
        end else begin
          s_nxt.bit_idx = s_r.bit_idx - 3'h1;
          s_nxt.so = s_r.shreg[s_r.bit_idx - 3'h1];
        end
      end
      // [RL24] Live ready while bit 7 stands
      if (s_r.kind == sfr_pkg::SFR_K_STATUS && s_nxt.bit_idx == 3'h7 && !s_nxt.load_next) begin
        s_nxt.so = ~i_busy;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.sy.cs_m <= 1'b1;
      s_r.sy.cs_s <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_so = s_r.so;
  assign o_so_oe = s_r.oe;
  assign o_mem_req_valid = s_r.req_valid;
  assign o_mem_req = s_r.req;
  assign o_mem_rsp_ready = fifo_in_ready;
endmodule // sfr_read_status
